/* design/tcid_pkg.sv */
package tcid_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] ADDR_CAP_ID_0 = 12'h020;     // Capability word, secure and non-secure view
    localparam logic [11:0] ADDR_SEC_CFG_1 = 12'h004;    // Secure allotment of context interrupts

    // ****************************************************************
    // Capability word fields
    // ****************************************************************
    localparam int SEC_EXT_POS = 31;
    localparam int FIRST_STAGE_POS = 30;
    localparam int SECOND_STAGE_POS = 29;
    localparam int NESTED_POS = 28;
    localparam int STREAM_MATCH_POS = 27;
    localparam int RSVD_HI_POS = 26;
    localparam int TABLE_FMT_LSB = 24;
    localparam int IRQ_COUNT_LSB = 16;
    localparam int RSVD_LO_POS = 15;
    localparam int SEC_CFG_IRQ_LSB = 0;

    // ****************************************************************
    // Field values
    // ****************************************************************
    localparam logic SEC_EXT_VAL = 1'h1;
    localparam logic FIRST_STAGE_VAL = 1'h0;
    localparam logic SECOND_STAGE_VAL = 1'h1;
    localparam logic NESTED_VAL = 1'h0;
    localparam logic STREAM_MATCH_VAL = 1'h1;
    localparam logic [1:0] TABLE_FMT_VAL = 2'h1;         // Long descriptor, 32-bit only
    localparam logic [7:0] IRQ_COUNT_PHYS = 8'h01;       // One context fault interrupt
    localparam logic [7:0] SEC_CFG_IRQ_RESET = 8'h01;    // All interrupts start non-secure

    typedef enum logic [1:0] {
        TCID_IDLE = 2'h0,
        TCID_ACCESS = 2'h1
    } tcid_state_type;

endpackage

/* design/tcid_regs.sv */
// Functional notes
// - Non-secure view shows the secure allotment in place of the physical interrupt count.
// - Nested translation bit 28 reads zero.
// - Bit 31 reads one, bit 30 zero.
// - Second stage bit 29 reads one.
// - Stream matching bit 27 reads one.
// - Table format field reads 01.
// - Interrupt count field reports one interrupt in the secure view.
// - Non-secure count comes from secure allotment.
module tcid_regs (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_pprot_ns,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr
);

    // ****************************************************************
    // Bus state
    // ****************************************************************
    tcid_pkg::tcid_state_type state_reg;
    logic [7:0] ns_irq_allot_reg;
    logic [31:0] sec_word;
    logic [31:0] ns_word;
    logic setup;
    logic hit_id;
    logic hit_cfg;
    logic is_read;

    assign setup = i_psel && !i_penable;
    assign hit_id = (i_paddr == tcid_pkg::ADDR_CAP_ID_0);
    assign hit_cfg = (i_paddr == tcid_pkg::ADDR_SEC_CFG_1);
    assign is_read = !i_pwrite;

    // Secure view shows physical count, non-secure the allotment
    tcid_word u_sec_word (
        .i_irq_count(tcid_pkg::IRQ_COUNT_PHYS),
        .o_word(sec_word)
    );
    tcid_word u_ns_word (
        .i_irq_count(ns_irq_allot_reg),
        .o_word(ns_word)
    );

    // No wait states: answer registered in setup, ready in the first access cycle
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= tcid_pkg::TCID_IDLE;
        end else begin
            unique case (state_reg)
                tcid_pkg::TCID_IDLE: begin
                    if (setup) begin
                        state_reg <= tcid_pkg::TCID_ACCESS;
                    end
                end
                tcid_pkg::TCID_ACCESS: begin
                    state_reg <= tcid_pkg::TCID_IDLE;
                end
                default: begin
                    state_reg <= tcid_pkg::TCID_IDLE;
                end
            endcase
        end
    end

    // Ready pulses for the access cycle only
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pready <= 1'h0;
        end else begin
            o_pready <= setup;
        end
    end

    // Read data captured at setup so it comes straight from a flop
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'h0;
        end else if (setup) begin
            o_pslverr <= !(hit_id || hit_cfg) || (hit_cfg && i_pprot_ns)
                || (hit_id && i_pwrite);
            if (is_read && hit_id) begin
                o_prdata <= i_pprot_ns ? ns_word : sec_word;
            end else if (is_read && hit_cfg && !i_pprot_ns) begin
                o_prdata <= {24'h00_0000, ns_irq_allot_reg};
            end else begin
                o_prdata <= 32'h0000_0000;
            end
        end else begin
            o_pslverr <= 1'h0;
            o_prdata <= 32'h0000_0000;
        end
    end

    // Secure allotment; non-secure writes are refused. Software keeps it
    // non-zero whenever it grants context banks, hardware does not police it.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ns_irq_allot_reg <= tcid_pkg::SEC_CFG_IRQ_RESET;
        end else if (i_psel && i_penable && o_pready && i_pwrite && hit_cfg
            && !i_pprot_ns) begin
            ns_irq_allot_reg <= i_pwdata[tcid_pkg::SEC_CFG_IRQ_LSB +: 8];
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Fixed capability bits, checked one by one so a single stuck bit is named
    a_fixed_top_bits: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && is_read && hit_id) |=> (o_prdata[31:27] == 5'h15))
        else $error("fixed capability bits wrong");

    a_sec_ext_set: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && is_read && hit_id) |=> o_prdata[31])
        else $error("security extension bit clear");

    a_first_stage_zero: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && is_read && hit_id) |=> !o_prdata[30])
        else $error("first stage bit set");

    a_second_stage: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && is_read && hit_id) |=> o_prdata[29] && o_pready)
        else $error("second stage bit clear");

    a_nested_zero: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && hit_id) |=> !o_prdata[28])
        else $error("nested bit set");

    a_stream_match: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && is_read && hit_id) |=> o_prdata[27])
        else $error("stream match bit clear");

    a_table_format: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && is_read && hit_id) |=> (o_prdata[25:24] == 2'h1))
        else $error("table format wrong");

    // Interrupt count: the only field in which the two views differ
    a_secure_count: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && is_read && hit_id && !i_pprot_ns) |=> (o_prdata[23:16] == 8'h01))
        else $error("physical interrupt count wrong");

    a_ns_count: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && is_read && hit_id && i_pprot_ns)
        |=> (o_prdata[23:16] == $past(ns_irq_allot_reg)))
        else $error("non-secure count not allotment");

    a_ns_fixed_bits: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && is_read && hit_id && i_pprot_ns)
        |=> (o_prdata[31:24] == 8'hA9 && o_prdata[15:0] == 16'h0000))
        else $error("non-secure view fixed bits wrong");

    // Secure allotment register: secure side reads and writes, others refused
    a_cfg_read_back: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && is_read && hit_cfg && !i_pprot_ns)
        |=> (o_prdata == {24'h00_0000, $past(ns_irq_allot_reg)} && !o_pslverr))
        else $error("allotment read back wrong");

    a_cfg_write_lands: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_psel && i_penable && o_pready && i_pwrite && hit_cfg && !i_pprot_ns)
        |=> (ns_irq_allot_reg == $past(i_pwdata[7:0])))
        else $error("allotment write lost");

    a_cfg_ns_refused: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && hit_cfg && i_pprot_ns)
        |=> (o_pslverr && o_prdata == 32'h0000_0000) ##1 $stable(ns_irq_allot_reg))
        else $error("non-secure allotment access accepted");

    // Read-only word and reserved bits; low bits belong to another block
    a_reserved_zero: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && hit_id)
        |=> (!o_prdata[26] && !o_prdata[15] && o_prdata[14:0] == 15'h0000))
        else $error("reserved bits set");

    a_write_refused: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && i_pwrite && hit_id) |=> o_pslverr ##1 $stable(ns_irq_allot_reg))
        else $error("identification write accepted");

    a_write_no_data: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && i_pwrite) |=> (o_prdata == 32'h0000_0000))
        else $error("write returned read data");

    a_unmapped_err: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (setup && !hit_id && !hit_cfg) |=> (o_pslverr && o_prdata == 32'h0000_0000))
        else $error("unmapped access not refused");

    a_refused_quiet: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_pslverr |-> (o_prdata == 32'h0000_0000 && o_pready))
        else $error("refused access carried data");

    // Handshake shape: ready is a single pulse tied to the access state
    a_ready_pulse: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_pready |=> !o_pready)
        else $error("ready held past one cycle");

    a_ready_state: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        (o_pready == (state_reg == tcid_pkg::TCID_ACCESS)))
        else $error("ready out of step with state");

    a_idle_quiet: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        !o_pready |-> (o_prdata == 32'h0000_0000 && !o_pslverr))
        else $error("response outside access cycle");

endmodule // tcid_regs

/* design/tcid_word.sv */
// Assembles the upper capability word from constants and an interrupt count
module tcid_word (
    input wire logic [7:0] i_irq_count,
    output logic [31:0] o_word
);
    // Fixed capability bits; low bits belong to another block and read zero
    always_comb begin
        o_word = 32'h0000_0000;
        o_word[tcid_pkg::SEC_EXT_POS] = tcid_pkg::SEC_EXT_VAL;
        o_word[tcid_pkg::FIRST_STAGE_POS] = tcid_pkg::FIRST_STAGE_VAL;
        o_word[tcid_pkg::SECOND_STAGE_POS] = tcid_pkg::SECOND_STAGE_VAL;
        o_word[tcid_pkg::NESTED_POS] = tcid_pkg::NESTED_VAL;
        o_word[tcid_pkg::STREAM_MATCH_POS] = tcid_pkg::STREAM_MATCH_VAL;
        o_word[tcid_pkg::RSVD_HI_POS] = 1'h0;
        o_word[tcid_pkg::TABLE_FMT_LSB +: 2] = tcid_pkg::TABLE_FMT_VAL;
        o_word[tcid_pkg::IRQ_COUNT_LSB +: 8] = i_irq_count;
        o_word[tcid_pkg::RSVD_LO_POS] = 1'h0;
    end
endmodule // tcid_word

/* tb/translation_capability_id_regs_test.sv */
module translation_capability_id_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Bench signals
    // ****************************************************************
    localparam logic [11:0] CAP = tcid_pkg::ADDR_CAP_ID_0;
    localparam logic [11:0] CFG = tcid_pkg::ADDR_SEC_CFG_1;
    logic clk, rstn, psel, penable, pwrite, pns, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] allot;
    int failures = 0;
    int total_checks = 0;

    tcid_regs uut (.i_core_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pprot_ns(pns),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));

    // 200 MHz core clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the idle edge first keeps back-to-back calls race free
    task automatic apb(input logic wr, input logic ns, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        pns <= ns;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) check(32'h0, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Fixed upper byte 1010_1001: security, second stage, matching, 32-bit long format
    function automatic logic [31:0] exp_word(input logic [7:0] cnt);
        return {8'hA9, cnt, 16'h0000};
    endfunction

    task automatic give_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {rstn, psel, penable, pwrite, pns} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        void'($urandom(87));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, 1'b0, CAP, 32'h0);
        check(rd, exp_word(8'h01));
        check({31'h0, er}, 32'h0);
        apb(1'b0, 1'b1, CAP, 32'h0);
        check(rd, exp_word(8'h01));
        // Allotment corners 0 and FF, then random values
        for (int i = 0; i < 6; i++) begin
            allot = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            // Zero stands for a grant of no context banks
            apb(1'b1, 1'b0, CFG, {24'h0, allot});
            check({31'h0, er}, 32'h0);
            apb(1'b0, 1'b1, CAP, 32'h0);
            check(rd, exp_word(allot));
            apb(1'b0, 1'b0, CAP, 32'h0);
            check(rd, exp_word(8'h01));
            apb(1'b1, i[0], CAP, $urandom);
            check({31'h0, er}, 32'h1);
            apb(1'b0, 1'b1, CAP, 32'h0);
            check(rd, exp_word(allot));
        end
        // Non-secure side may not touch the allotment
        apb(1'b1, 1'b1, CFG, 32'h0000_0055);
        check({31'h0, er}, 32'h1);
        apb(1'b0, 1'b1, CFG, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        apb(1'b0, 1'b0, CFG, 32'h0);
        check(rd, {24'h0, allot});
        apb(1'b0, 1'b0, 12'h0FC, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        // Mid-run reset brings the allotment back to one
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, 1'b1, CAP, 32'h0);
        check(rd, exp_word(8'h01));
        give_verdict;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        give_verdict;
    end
endmodule // translation_capability_id_regs_test
